// ===== core/count_core.sv
// Four-bit decade or binary up/down counting core with cascade outputs
`include "updown_defs.svh"

module count_core #(
	parameter int COUNT_WIDTH = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	counter_if.core  link
);

	generate
		if (COUNT_WIDTH != 4) begin : g_width_check
			$error("count_core supports a four-bit state only");
		end
	endgenerate

	// Wrap points; illegal decade states fold back within one count
	function automatic updown_pkg::count_t step_value(
		input updown_pkg::count_t value,
		input logic               down,
		input logic               decade
	);
		updown_pkg::count_t result;
		if (down) begin
			if (value == `COUNT_MIN) begin
				result = decade ? `DECADE_MAX : `BINARY_MAX; // [RULE_06] [RULE_08]
			end else if (decade && value > `DECADE_MAX) begin
				result = `DECADE_MAX; // [RULE_11]
			end else begin
				result = value - 4'h1; // [RULE_03]
			end
		end else begin
			if (decade && value >= `DECADE_MAX) begin
				result = `COUNT_MIN; // [RULE_05] [RULE_11]
			end else begin
				result = value + 4'h1; // [RULE_03] [RULE_07]
			end
		end
		return result;
	endfunction

	// Maximum when counting up, minimum when counting down
	function automatic logic is_terminal(
		input updown_pkg::count_t value,
		input logic               down,
		input logic               decade
	);
		logic hit;
		if (down) begin
			hit = (value == `COUNT_MIN);
		end else begin
			hit = decade ? (value == `DECADE_MAX) : (value == `BINARY_MAX);
		end
		return hit; // [RULE_13]
	endfunction

	updown_pkg::count_t count;
	updown_pkg::count_t next_count;
	logic               terminal_count;
	logic               ripple_clock_n;

	always_comb begin
		if (!link.preset_n) begin
			next_count = link.preset_value; // [RULE_01] [RULE_14]
		end else if (!link.count_enable_n) begin
			next_count = step_value(count, link.count_down, link.decade); // [RULE_02]
		end else begin
			next_count = count; // [RULE_02]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= `COUNT_MIN;
		end else begin
			count <= next_count; // [RULE_04]
		end
	end

	// Registered decode lines up with the state it describes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			terminal_count <= 1'b0;
		end else begin
			terminal_count <= is_terminal(next_count, link.count_down, link.decade); // [RULE_09]
		end
	end

	// Full-cycle low pulse: no half-clock phase exists in a synchronous core
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ripple_clock_n <= 1'b1;
		end else begin
			ripple_clock_n <= !(is_terminal(next_count, link.count_down, link.decade)
				&& !link.count_enable_n && link.preset_n); // [RULE_10] [RULE_13]
		end
	end

	assign link.count          = count; // [RULE_14]
	assign link.terminal_count = terminal_count;
	assign link.ripple_clock_n = ripple_clock_n;

endmodule

// ===== core/counter_if.sv
// Control and result signals between register front end and counting core
interface counter_if;
	logic                  preset_n;
	updown_pkg::count_t    preset_value;
	logic                  count_enable_n;
	logic                  count_down;
	logic                  decade;
	updown_pkg::count_t    count;
	logic                  terminal_count;
	logic                  ripple_clock_n;

	modport ctrl (
		output preset_n,
		output preset_value,
		output count_enable_n,
		output count_down,
		output decade,
		input  count,
		input  terminal_count,
		input  ripple_clock_n
	);

	modport core (
		input  preset_n,
		input  preset_value,
		input  count_enable_n,
		input  count_down,
		input  decade,
		output count,
		output terminal_count,
		output ripple_clock_n
	);
endinterface

// ===== core/updown_counter.sv
// AXI4-Lite register front end and top level of the up/down counter
//
// What this block does
// (RULE_01) While preset is low the count state copies the four preset inputs, whatever else.
// (RULE_02) The state counts only with preset high and count enable low, else it holds.
// (RULE_03) When counting, direction high decrements and direction low increments.
// (RULE_04) Each count step takes effect on the rising clock edge.
// (RULE_05) Decade mode counting up treats 9 as maximum and wraps to 0.
// (RULE_06) Decade mode counting down treats 0 as minimum and wraps to 9.
// (RULE_07) Binary mode counting up treats 15 as maximum and wraps to 0.
// (RULE_08) Binary mode counting down treats 0 as minimum and wraps to 15.
// (RULE_09) Terminal count stays low while counting and is high one cycle at wrap.
// (RULE_10) Ripple clock idles high and pulses low on the terminal condition.
// (RULE_11) A decade state above 9 returns to the normal sequence within one or two counts.
// (RULE_12) The controller changes direction and enable only while the clock is high.
// (RULE_13) Terminal count decodes maximum up and minimum down; ripple needs enable low.
// (RULE_14) Preset bit A is the state LSB and D the MSB; state bits drive the count outputs.
`include "updown_defs.svh"

module updown_counter #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ADDR_WIDTH-1:0] awaddr,
	input  wire logic [2:0]            awprot,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [ADDR_WIDTH-1:0] araddr,
	input  wire logic [2:0]            arprot,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	output logic [3:0]                 count,
	output logic                       terminal_count,
	output logic                       ripple_clock_n
);

	generate
		if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) begin : g_addr_check
			$error("updown_counter needs an address width of 4 to 32 bits");
		end
	endgenerate

	// Byte-lane merge for writable registers
	function automatic logic [31:0] merge_lanes(
		input logic [31:0] old_word,
		input logic [31:0] new_word,
		input logic [3:0]  strobe
	);
		logic [31:0] result;
		result = old_word;
		for (int lane = 0; lane < 4; lane++) begin
			if (strobe[lane]) begin
				result[lane*8 +: 8] = new_word[lane*8 +: 8];
			end
		end
		return result;
	endfunction

	// Word offset inside the decoded window
	function automatic logic [7:0] word_offset(input logic [ADDR_WIDTH-1:0] addr);
		logic [31:0] wide;
		wide = 32'h0;
		wide[ADDR_WIDTH-1:0] = addr;
		return {wide[7:2], 2'h0};
	endfunction

	function automatic logic in_window(input logic [ADDR_WIDTH-1:0] addr);
		logic [31:0] wide;
		wide = 32'h0;
		wide[ADDR_WIDTH-1:0] = addr;
		return wide[31:8] == 24'h0;
	endfunction

	counter_if link ();

	// Software-visible control
	logic [31:0] ctrl_reg;
	logic [31:0] preset_reg;
	logic [31:0] ctrl_merged;
	logic [31:0] preset_merged;

	// Write channel state
	updown_pkg::wr_state_t   wr_state;
	updown_pkg::wr_state_t   next_wr_state;
	logic                    aw_held;
	logic                    w_held;
	logic                    next_aw_held;
	logic                    next_w_held;
	logic [ADDR_WIDTH-1:0]   wr_addr;
	logic [31:0]             wr_data;
	logic [3:0]              wr_strb;
	logic                    commit;
	logic                    wr_hit_ctrl;
	logic                    wr_hit_preset;

	// Read channel state
	updown_pkg::rd_state_t   rd_state;
	updown_pkg::rd_state_t   next_rd_state;
	logic                    ar_fire;
	logic [31:0]             read_word;
	logic [1:0]              read_resp;

	// Control levels handed to the counting core; bus writes land on a clock
	// edge, so enable and direction never move in the sensitive half period
	assign link.preset_n       = ctrl_reg[`CTRL_PRESET_N_BIT]; // [RULE_12]
	assign link.count_enable_n = ctrl_reg[`CTRL_ENABLE_N_BIT]; // [RULE_12]
	assign link.count_down     = ctrl_reg[`CTRL_DOWN_BIT];
	assign link.decade         = ctrl_reg[`CTRL_DECADE_BIT];
	assign link.preset_value   = preset_reg[3:0]; // [RULE_14]

	count_core #(
		.COUNT_WIDTH(4)
	) u_core (
		.aclk    (aclk),
		.aresetn (aresetn),
		.link    (link)
	);

	assign count          = link.count;
	assign terminal_count = link.terminal_count;
	assign ripple_clock_n = link.ripple_clock_n;

	// Write path: address and data taken in either order
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
		end
		if (commit) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
		end
	end

	assign commit        = (wr_state == updown_pkg::WR_COLLECT) && aw_held && w_held;
	assign wr_hit_ctrl   = in_window(wr_addr) && word_offset(wr_addr) == `CTRL_OFFSET;
	assign wr_hit_preset = in_window(wr_addr) && word_offset(wr_addr) == `PRESET_OFFSET;

	always_comb begin
		case (wr_state)
			updown_pkg::WR_COLLECT: begin
				next_wr_state = commit ? updown_pkg::WR_RESP : updown_pkg::WR_COLLECT;
			end
			updown_pkg::WR_RESP: begin
				next_wr_state = bready ? updown_pkg::WR_COLLECT : updown_pkg::WR_RESP;
			end
			default: begin
				next_wr_state = updown_pkg::WR_COLLECT;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state <= updown_pkg::WR_COLLECT;
		end else begin
			wr_state <= next_wr_state;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
		end
	end

	// Ready drops after the first beat until the response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b0;
			wready  <= 1'b0;
		end else begin
			awready <= (next_wr_state == updown_pkg::WR_COLLECT) && !next_aw_held;
			wready  <= (next_wr_state == updown_pkg::WR_COLLECT) && !next_w_held;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_addr <= '0;
		end else if (awvalid && awready) begin
			wr_addr <= awaddr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_data <= 32'h0;
			wr_strb <= 4'h0;
		end else if (wvalid && wready) begin
			wr_data <= wdata;
			wr_strb <= wstrb;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= `RESP_OKAY;
		end else if (commit) begin
			bvalid <= 1'b1;
			bresp  <= (wr_hit_ctrl || wr_hit_preset) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// Only the low nibble of each control register is implemented
	assign ctrl_merged   = merge_lanes(ctrl_reg, wr_data, wr_strb);
	assign preset_merged = merge_lanes(preset_reg, wr_data, wr_strb);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= `CTRL_RESET;
		end else if (commit && wr_hit_ctrl) begin
			ctrl_reg <= {28'h0, ctrl_merged[3:0]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			preset_reg <= `PRESET_RESET;
		end else if (commit && wr_hit_preset) begin
			preset_reg <= {28'h0, preset_merged[3:0]};
		end
	end

	// Read path: one outstanding read, answered the cycle after it is taken
	assign ar_fire = arvalid && arready;

	always_comb begin
		read_word = 32'h0;
		read_resp = `RESP_OKAY;
		if (!in_window(araddr)) begin
			read_resp = `RESP_SLVERR;
		end else begin
			case (word_offset(araddr))
				`CTRL_OFFSET: begin
					read_word = ctrl_reg;
				end
				`PRESET_OFFSET: begin
					read_word = preset_reg;
				end
				`STATUS_OFFSET: begin
					read_word[3:0]                = link.count;
					read_word[`STATUS_TC_BIT]     = link.terminal_count;
					read_word[`STATUS_RIPPLE_BIT] = link.ripple_clock_n;
				end
				default: begin
					read_resp = `RESP_SLVERR;
				end
			endcase
		end
	end

	always_comb begin
		case (rd_state)
			updown_pkg::RD_ADDR: begin
				next_rd_state = ar_fire ? updown_pkg::RD_DATA : updown_pkg::RD_ADDR;
			end
			updown_pkg::RD_DATA: begin
				next_rd_state = rready ? updown_pkg::RD_ADDR : updown_pkg::RD_DATA;
			end
			default: begin
				next_rd_state = updown_pkg::RD_ADDR;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state <= updown_pkg::RD_ADDR;
			arready  <= 1'b0;
		end else begin
			rd_state <= next_rd_state;
			arready  <= (next_rd_state == updown_pkg::RD_ADDR);
		end
	end

	// Status is sampled when the address is taken, not when data is accepted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0;
			rresp  <= `RESP_OKAY;
		end else if (ar_fire) begin
			rvalid <= 1'b1;
			rdata  <= read_word;
			rresp  <= read_resp;
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule

// ===== core/updown_defs.svh
// Offsets, field positions, reset values and count limits of the up/down counter
`ifndef UPDOWN_DEFS_SVH
`define UPDOWN_DEFS_SVH

`define CTRL_OFFSET        8'h00
`define STATUS_OFFSET      8'h04
`define PRESET_OFFSET      8'h08

`define CTRL_PRESET_N_BIT  0
`define CTRL_ENABLE_N_BIT  1
`define CTRL_DOWN_BIT      2
`define CTRL_DECADE_BIT    3
`define CTRL_RESET         32'h0000_0003
`define PRESET_RESET       32'h0000_0000

`define STATUS_TC_BIT      4
`define STATUS_RIPPLE_BIT  5

`define COUNT_MIN          4'h0
`define DECADE_MAX         4'h9
`define BINARY_MAX         4'hf

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== core/updown_pkg.sv
// Types shared by the up/down counter modules
package updown_pkg;

	typedef logic [3:0] count_t;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b01,
		WR_RESP    = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		RD_ADDR = 2'b01,
		RD_DATA = 2'b10
	} rd_state_t;

endpackage

// ===== tb/carry_stage.sv
// Next cascaded stage: counts ripple pulses of this counter
module carry_stage (
	input wire logic  aclk,
	input wire logic  aresetn,
	input wire logic  ripple_clock_n,
	output logic [7:0] carries
);
	timeunit 1ns;
	timeprecision 1ps;
	// Full-cycle low pulse, so one sample per pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			carries <= 8'h00;
		end else if (!ripple_clock_n) begin
			carries <= carries + 8'h01;
		end
	end
endmodule

// ===== tb/presettable_up_down_counter_tb.sv
// Self-checking bench for the up/down counter
`include "updown_defs.svh"
module presettable_up_down_counter_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic               aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bv_d;
	logic               awready, wready, bvalid, arready, rvalid, tc, rip, etc, erip;
	logic [7:0]         awaddr, araddr, wa, carries, ecar;
	logic [31:0]        wdata, rdata, wd;
	logic [3:0]         wstrb, ctl;
	logic [1:0]         bresp, rresp;
	updown_pkg::count_t count, cnt, pre, mx, nx;
	logic [33:0]        rq[$];
	logic [1:0]         bq[$];
	int                 error_cnt, checked, cyc;

	updown_counter i_updown_counter (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .count(count),
		.terminal_count(tc), .ripple_clock_n(rip));
	carry_stage i_carry_stage (.aclk(aclk), .aresetn(aresetn), .ripple_clock_n(rip),
		.carries(carries));

	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Requests change just after a rising edge, while the clock is high
	// One idle edge first, so a lowered ready is never raised in the same step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic b_done;
		b_done = 1'b0;
		bq.push_back(r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				b_done = 1'b1;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		logic r_done;
		r_done = 1'b0;
		rq.push_back(e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				r_done = 1'b1;
			end
		end
	endtask

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Reference counter; a write lands one edge before bvalid is sampled
	always @(posedge aclk) begin
		if (!aresetn) begin
			ctl = `CTRL_RESET;
			pre = 4'h0;
			cnt <= 4'h0;
			etc <= 1'b0;
			erip <= 1'b1;
		end else begin
			if (awvalid && awready) wa = awaddr;
			if (wvalid && wready) wd = wdata;
			if (bvalid && !bv_d && bresp == `RESP_OKAY) begin
				if (wa == `CTRL_OFFSET) ctl = wd[3:0];
				else pre = wd[3:0];
			end
			mx = ctl[3] ? `DECADE_MAX : `BINARY_MAX;
			if (!ctl[0]) nx = pre;
			else if (ctl[1]) nx = cnt;
			else if (ctl[2]) nx = (cnt == 4'h0) ? mx : (cnt > mx) ? 4'h9 : cnt - 4'h1;
			else nx = (cnt >= mx) ? 4'h0 : cnt + 4'h1;
			etc <= ctl[2] ? (nx == 4'h0) : (nx == mx);
			erip <= !(ctl[0] && !ctl[1] && (ctl[2] ? (nx == 4'h0) : (nx == mx)));
			cnt <= nx;
		end
		bv_d <= bvalid;
		if (rvalid && rready) chk("read", {rresp, rdata}, rq.pop_front());
		if (bvalid && bready) chk("bresp", bresp, bq.pop_front());
		cyc++;
		if (cyc > 3000) begin
			error_cnt++;
			conclude();
		end
	end

	// Settled outputs looked at mid-cycle
	always @(negedge aclk) begin
		if (aresetn) begin
			chk("count", count, cnt);
			chk("terminal", tc, etc);
			chk("ripple", rip, erip);
			if (!erip) ecar++;
		end
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, bv_d} = 7'h0;
		{awaddr, araddr, wdata, ecar} = 56'h0;
		wstrb = 4'hf;
		error_cnt = 0;
		checked = 0;
		cyc = 0;
		void'($urandom(789));
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`CTRL_OFFSET, {2'h0, `CTRL_RESET});
		rd(`PRESET_OFFSET, {2'h0, `PRESET_RESET});
		rd(`STATUS_OFFSET, 34'h20);
		wr(8'h0c, 32'h5, `RESP_SLVERR);
		rd(8'h0c, {`RESP_SLVERR, 32'h0});
		wr(`STATUS_OFFSET, 32'h1, `RESP_SLVERR);
		// Modes by {decade, down}; last one starts from an illegal decade state
		for (int m = 0; m < 4; m++) begin
			wr(`PRESET_OFFSET, (m == 3) ? 32'hc : $urandom, `RESP_OKAY);
			wr(`CTRL_OFFSET, {28'h0, m[1:0], 2'b10}, `RESP_OKAY);
			wr(`CTRL_OFFSET, {28'h0, m[1:0], 2'b01}, `RESP_OKAY);
			repeat (20) @(posedge aclk);
			wr(`CTRL_OFFSET, {28'h0, m[1:0], 2'b11}, `RESP_OKAY);
			// Let the stale ripple from the last enabled edge clear first
			@(posedge aclk);
			rd(`STATUS_OFFSET, {26'h0, erip, etc, cnt});
		end
		chk("carries", carries, ecar);
		conclude();
	end
endmodule

// ===== tb/updown_counter_props.sv
// Port-level checks of the up/down counter
module updown_counter_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [3:0]  count,
	input wire logic        terminal_count,
	input wire logic        ripple_clock_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wr_taken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_taken;
		arvalid && arready;
	endsequence
	property p_wr_resp; s_wr_taken |-> ##2 bvalid; endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response late");
	property p_rd_resp; s_rd_taken |=> rvalid; endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read data late");
	property p_aw_busy; s_wr_taken |=> !awready && !wready; endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("write ready not dropped");
	property p_ar_busy; s_rd_taken |=> !arready; endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("read ready not dropped");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped");
	property p_tc_val; terminal_count |-> count inside {4'h0, 4'h9, 4'hf}; endproperty
	a_tc_val: assert property (p_tc_val) else $error("terminal count off limit");
	property p_rip_tc; !ripple_clock_n |-> terminal_count; endproperty
	a_rip_tc: assert property (p_rip_tc) else $error("ripple without terminal");
	property p_rip_one; !ripple_clock_n |=> ripple_clock_n; endproperty
	a_rip_one: assert property (p_rip_one) else $error("ripple pulse too long");
endmodule

bind updown_counter updown_counter_props i_updown_counter_props (.aclk(aclk),
	.aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
	.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .count(count),
	.terminal_count(terminal_count), .ripple_clock_n(ripple_clock_n));
